// *** srst_ctrl.sv ***
// System reset input control: synchronised reset, strap capture, boot fetch
// Notes on behaviour
// RL1: The reset input is active low and resets internal logic at once, with no clock edge needed.
// RL2: While reset is held, every peripheral interface register is forced to its default.
// RL3: After release the first instruction fetch is taken from address zero.
// RL4: The same reset also initialises the debug test access port controller.
// RL5: Boot configuration straps are sampled while reset is applied, for use after release.
// RL6: Assertion may be at any time, but release takes effect only in step with the clock.
// RL7: The external source holds reset low at least 92 us for each pulse.
// RL8: Asserting reset halts the instruction in progress at once, regardless of the clock.
// RL9: Reset defines only the program counter and the status register of the processor.
// RL10: At power-up the source holds reset until supplies and the slow oscillator are stable.
// RL11: The source also asserts reset on falling supply or brownout.
// RL12: Cold and user resets share one signal; user resets may be shorter than cold ones.
// RL13: Release passes at least two flip-flops, set asynchronously on assertion.
`timescale 1ns/100ps
`default_nettype none
module srst_ctrl
  import srst_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_system_reset_in_n,
  input wire logic [SRST_STRAP_W-1:0] i_boot_strap,
  output logic o_periph_rst_n,
  output logic o_tap_rst_n,
  output logic o_cpu_halt,
  output logic o_fetch_zero,
  output logic [31:0] o_pc_init,
  output logic [7:0] o_status_init,
  output logic [SRST_STRAP_W-1:0] o_boot_strap,
  output logic o_short_pulse
);
  logic rst_n;
  logic [SRST_STRAP_W-1:0] strap_m;
  logic [SRST_STRAP_W-1:0] strap_s;
  logic [SRST_STRAP_W-1:0] strap;
  logic [SRST_STRAP_W-1:0] next_strap;
  srst_state_t state;
  srst_state_t next_state;
  logic [15:0] low_cnt;
  logic [15:0] next_low_cnt;
  logic short_pulse;
  logic next_short_pulse;
  logic seen_low;

  // RL6 clock-aligned release
  srst_sync u_sync (
    .i_clk(i_clk),
    .i_system_reset_in_n(i_system_reset_in_n),
    .o_rst_n(rst_n)
  );

  // RL2 peripheral defaults while held
  assign o_periph_rst_n = rst_n;
  // RL4 debug port reset too
  assign o_tap_rst_n = rst_n;
  // RL8 halt without clock
  assign o_cpu_halt = !i_system_reset_in_n || (state == SRST_HELD);

  // Straps pass two flops before capture
  // Not reset by the pin, or the capture would see only the default
  always_ff @(posedge i_clk) begin
    strap_m <= i_boot_strap;
    strap_s <= strap_m;
  end

  // RL5 capture while reset still internal
  always_comb begin
    next_strap = strap;
    if (!rst_n) begin
      next_strap = strap_s;
    end
  end

  always_ff @(posedge i_clk) begin
    strap <= next_strap;
  end

  // RL3 boot sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      SRST_HELD: begin
        next_state = SRST_FETCH;
      end
      SRST_FETCH: begin
        next_state = SRST_RUN;
      end
      SRST_RUN: begin
        next_state = SRST_RUN;
      end
    endcase
  end

  // RL1 asynchronous entry to held state
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SRST_HELD;
    end else begin
      state <= next_state;
    end
  end

  assign o_fetch_zero = (state == SRST_FETCH);
  // RL9 only program counter and status defined
  assign o_pc_init = SRST_RESET_VECTOR;
  assign o_status_init = SRST_STATUS_DEFAULT;
  assign o_boot_strap = strap;

  // RL7 flags pulses under the minimum width
  // Counting runs on the clock while the synchronised reset rst_n is low; a stopped clock gives no count.
  always_comb begin
    next_low_cnt = low_cnt;
    next_short_pulse = short_pulse;
    if (!rst_n) begin
      if (low_cnt != 16'hFFFF) begin
        next_low_cnt = low_cnt + 16'h0001;
      end
    end else begin
      if (seen_low) begin
        next_short_pulse = (low_cnt < 16'(SRST_MIN_PULSE_CYC));
      end
      next_low_cnt = 16'h0000;
    end
  end

  always_ff @(posedge i_clk) begin
    low_cnt <= next_low_cnt;
    short_pulse <= next_short_pulse;
  end

  assign seen_low = (low_cnt != 16'h0000);
  assign o_short_pulse = short_pulse;
endmodule
`default_nettype wire

// *** srst_pkg.sv ***
// Constants and types shared by the system reset input control block
package srst_pkg;
  localparam int SRST_SYNC_STAGES = 2;
  localparam int SRST_STRAP_W = 4;
  localparam logic [31:0] SRST_RESET_VECTOR = 32'h0000_0000;
  localparam logic [7:0] SRST_STATUS_DEFAULT = 8'hD3;
  localparam logic [SRST_STRAP_W-1:0] SRST_STRAP_DEFAULT = 4'h0;
  localparam int SRST_CLK_MHZ = 20;
  localparam int SRST_MIN_PULSE_US = 92;
  localparam int SRST_MIN_PULSE_CYC = SRST_MIN_PULSE_US * SRST_CLK_MHZ;
  typedef enum logic [1:0] {
    SRST_HELD,
    SRST_FETCH,
    SRST_RUN
  } srst_state_t;
endpackage

// *** srst_sync.sv ***
// Reset release synchroniser: asynchronous assert, clocked release
`timescale 1ns/100ps
`default_nettype none
module srst_sync
  import srst_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_system_reset_in_n,
  output logic o_rst_n
);
  logic [SRST_SYNC_STAGES-1:0] stage;
  logic [SRST_SYNC_STAGES-1:0] next_stage;

  always_comb begin
    next_stage = {stage[SRST_SYNC_STAGES-2:0], 1'b1};
  end

  // RL13 two-flop release chain
  always_ff @(posedge i_clk or negedge i_system_reset_in_n) begin
    if (!i_system_reset_in_n) begin
      stage <= '0;
    end else begin
      stage <= next_stage;
    end
  end

  assign o_rst_n = stage[SRST_SYNC_STAGES-1];
endmodule
`default_nettype wire

// *** srst_checker.sv ***
// Assertion checker for the system reset input control ports
`timescale 1ns/100ps
`default_nettype none
module srst_checker (
  input wire logic i_clk,
  input wire logic i_system_reset_in_n,
  input wire logic o_periph_rst_n,
  input wire logic o_tap_rst_n,
  input wire logic o_cpu_halt,
  input wire logic o_fetch_zero,
  input wire logic [31:0] o_pc_init,
  input wire logic [7:0] o_status_init,
  input wire logic [3:0] o_boot_strap
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_system_reset_in_n);
  sequence rel_s; !o_periph_rst_n [*2] ##1 o_periph_rst_n; endsequence
  sequence boot_s; o_cpu_halt ##1 o_fetch_zero ##1 !o_fetch_zero && !o_cpu_halt; endsequence
  pin_low_a: assert property (disable iff (1'b0) !i_system_reset_in_n |-> !o_periph_rst_n && o_cpu_halt) else $error("no reset");
  tap_follow_a: assert property (o_tap_rst_n == o_periph_rst_n) else $error("tap reset");
  sync_rel_a: assert property ($rose(i_system_reset_in_n) |-> rel_s) else $error("release timing");
  boot_seq_a: assert property ($rose(o_periph_rst_n) |-> boot_s) else $error("boot order");
  fetch_pc_a: assert property (o_fetch_zero |-> o_pc_init == 32'h0) else $error("fetch address");
  status_def_a: assert property (o_fetch_zero |-> o_status_init == 8'hD3) else $error("status value");
  strap_hold_a: assert property (o_periph_rst_n && $past(o_periph_rst_n) |-> $stable(o_boot_strap)) else $error("straps");
  halt_run_a: assert property (!o_cpu_halt |-> o_periph_rst_n) else $error("early run");
endmodule
bind srst_ctrl srst_checker chk (.*);
`default_nettype wire

// *** srst_supervisor.sv ***
// Behavioural external reset source: supervisor or manual button
`timescale 1ns/100ps
`default_nettype none
module srst_supervisor (
  input wire logic i_clk,
  output logic o_system_reset_in_n
);
  // Idle high; the bench pulls it low at time zero for a clean falling edge
  initial o_system_reset_in_n = 1'b1;
  task automatic pulse(input int n);
    o_system_reset_in_n <= 1'b0;
    repeat (n) @(posedge i_clk);
    o_system_reset_in_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// *** srst_ctrl_bench.sv ***
// Self-checking bench for the system reset input control block
`timescale 1ns/100ps
`default_nettype none
module srst_ctrl_bench;
  import srst_pkg::*;
  logic i_clk = 1'b0;
  logic i_system_reset_in_n;
  logic [SRST_STRAP_W-1:0] i_boot_strap = 4'hA;
  logic o_periph_rst_n, o_tap_rst_n, o_cpu_halt, o_fetch_zero, o_short_pulse;
  logic [31:0] o_pc_init;
  logic [7:0] o_status_init;
  logic [SRST_STRAP_W-1:0] o_boot_strap;
  int mismatches = 0;
  int check_count = 0;
  int cyc = 0;
  always #25 i_clk = ~i_clk;
  srst_supervisor sup (.i_clk, .o_system_reset_in_n(i_system_reset_in_n));
  srst_ctrl dut (.*);
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One reset pulse of n cycles, straps s, expected short flag sh
  task automatic run_pulse(input int n, input logic [3:0] s, input logic sh);
    int k;
    k = 0;
    @(posedge i_clk) i_boot_strap <= s;
    repeat (3) @(posedge i_clk);
    fork sup.pulse(n); join_none
    // No clock edge passes before this look
    #1 chk(!o_periph_rst_n && !o_tap_rst_n && o_cpu_halt, "no async reset");
    while (o_fetch_zero !== 1'b1 && k < 4000) begin
      @(posedge i_clk) #1 k++;
    end
    chk(o_pc_init === 32'h0 && o_status_init === 8'hD3, "boot state");
    chk(o_boot_strap === s, "straps");
    chk(o_short_pulse === sh, "pulse flag");
    @(posedge i_clk) #1 chk(!o_fetch_zero && !o_cpu_halt, "still halted");
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 8000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    // Cold reset, held 12 cycles; pulse flag is undefined after it
    sup.pulse(12);
    repeat (4) @(posedge i_clk);
    run_pulse(8, 4'hA, 1'b1);
    run_pulse(SRST_MIN_PULSE_CYC - 8, 4'h5, 1'b1);
    run_pulse(SRST_MIN_PULSE_CYC, 4'h3, 1'b0);
    run_pulse(12, 4'hC, 1'b1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
